// >>> core/spel_pkg.sv
// Constants shared by the phy event log block.
// Behaviour
// - Report negotiated rate as 8h/9h/Ah/Bh for 1.5G..12.0G while phy enabled.
// - Eight-bit generation counter steps by one on each phy mode settings change.
// - Generation 00h means unknown; after FFh the next step gives 01h.
// - Count invalid dwords outside phy reset sequences; saturate at maximum.
// - Count disparity errors only while dword sync is held; saturate at maximum.
// - Count dword sync losses that restart link reset; saturate at maximum.
// - Count phy reset sequences failing speed-match sync; saturate at maximum.
// - Capture attached device type and initiator and target bits from received frame.
// - Store far-end address and far-end phy identifier from received frame.
// - Report own address as the one sent in the outgoing frame.
// - Attached reason copies received reason; zero after SATA D2H FIS or virtual phy; a frame received while SATA attached is not copied.
// - Own reason is the cause sent in the last transmitted frame.
// - Each event descriptor is 0Ch bytes long.
// - Exactly 04h event descriptors are reported.
// - Descriptors tagged 01h, 02h, 03h carry counts since power-on.
// - Fourth descriptor tagged 04h carries reset problem count since power-on.
// - Peak threshold of every descriptor reads as all zeros.
// - Event value then threshold, each four bytes, most significant byte first.
package spel_pkg;
  // Register word addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_GEN = 8'h10;
  localparam logic [7:0] ADDR_LOG_BASE = 8'h80;
  localparam logic [7:0] ADDR_LOG_LAST = 8'hDC;
  localparam int LOG_WORDS = 24;
  // Control and status field positions.
  localparam int CTRL_PHY_EN_BIT = 0;
  localparam int INT_RX_IDF = 0;
  localparam int INT_LINK_UP = 1;
  localparam int INT_SYNC_LOST = 2;
  localparam int INT_RST_PROBLEM = 3;
  localparam int INT_W = 4;
  // Event indices.
  localparam int EV_INVALID = 0;
  localparam int EV_DISP = 1;
  localparam int EV_SYNC = 2;
  localparam int EV_RSTPRB = 3;
  localparam int EV_N = 4;
  // Reset values and codes.
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [INT_W-1:0] MASK_RESET = 4'h0;
  localparam logic [3:0] RATE_CODE_BASE = 4'h8;
  localparam logic [3:0] RATE_UNKNOWN = 4'h0;
  localparam logic [3:0] REASON_NONE = 4'h0;
  localparam logic [7:0] GEN_UNKNOWN = 8'h00;
  localparam logic [7:0] GEN_MAX = 8'hFF;
  localparam logic [7:0] GEN_WRAP = 8'h01;
  localparam logic [7:0] DESC_LEN = 8'h0C;
  localparam logic [7:0] DESC_COUNT = 8'h04;
  localparam logic [7:0] SRC_INVALID = 8'h01;
  localparam logic [7:0] SRC_DISP = 8'h02;
  localparam logic [7:0] SRC_SYNC = 8'h03;
  localparam logic [7:0] SRC_RSTPRB = 8'h04;
  localparam logic [31:0] PEAK_THRESH = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
endpackage

// >>> core/spel_cnt_if.sv
// Interface between the log core and its event counter bank.
`timescale 1ns/1ps
interface spel_cnt_if;
  logic [spel_pkg::EV_N-1:0] inc;
  logic [spel_pkg::EV_N-1:0][31:0] cnt;
  modport core (output inc, input cnt);
  modport bank (input inc, output cnt);
endinterface

// >>> core/spel_counters.sv
// Bank of four saturating phy event counters.
`timescale 1ns/1ps
module spel_counters
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // Increment requests and counts.
  spel_cnt_if.bank cif
);

  // Each counter steps once per request and sticks at its maximum.
  always_ff @(posedge i_clock)
  begin
    for (int i = 0; i < spel_pkg::EV_N; i++)
    begin
      if (i_srst)
        cif.cnt[i] <= spel_pkg::CNT_RESET;
      else if (cif.inc[i] && cif.cnt[i] != spel_pkg::CNT_MAX)
        cif.cnt[i] <= cif.cnt[i] + 32'h0000_0001;
    end
  end

  // Checks on the counter bank.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  property p_cnt_saturate;
    (cif.inc[spel_pkg::EV_INVALID] && cif.cnt[spel_pkg::EV_INVALID] == spel_pkg::CNT_MAX)
      |=> cif.cnt[spel_pkg::EV_INVALID] == spel_pkg::CNT_MAX;
  endproperty
  a_cnt_saturate: assert property (p_cnt_saturate) else $error("Invalid dword count wrapped.");

  property p_cnt_step;
    (cif.inc[spel_pkg::EV_DISP] && cif.cnt[spel_pkg::EV_DISP] != spel_pkg::CNT_MAX)
      |=> cif.cnt[spel_pkg::EV_DISP] == $past(cif.cnt[spel_pkg::EV_DISP]) + 32'h0000_0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("Disparity count did not step by one.");

  property p_cnt_no_decrement;
    ##1 cif.cnt[spel_pkg::EV_SYNC] >= $past(cif.cnt[spel_pkg::EV_SYNC]);
  endproperty
  a_cnt_no_decrement: assert property (p_cnt_no_decrement) else $error("Sync loss count fell.");

  c_cnt_saturated: cover property (cif.cnt[spel_pkg::EV_RSTPRB] == spel_pkg::CNT_MAX);

endmodule

// >>> core/spel_top.sv
// Phy identification capture, link rate, generation code and event log window.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module spel_top
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port.
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Received identification frame.
  input wire logic i_rx_idf_valid,
  input wire logic [2:0] i_rx_dev_type,
  input wire logic [2:0] i_rx_init_bits,
  input wire logic [2:0] i_rx_tgt_bits,
  input wire logic [63:0] i_rx_sas_addr,
  input wire logic [7:0] i_rx_phy_id,
  input wire logic [3:0] i_rx_reason,
  // Transmitted identification frame.
  input wire logic i_tx_idf_valid,
  input wire logic [63:0] i_tx_sas_addr,
  input wire logic [3:0] i_tx_reason,
  // Attachment kind.
  input wire logic i_sata_attached,
  input wire logic i_sata_d2h_fis,
  input wire logic i_virtual_phy,
  // Link reset outcome.
  input wire logic i_link_up,
  input wire logic [1:0] i_rate_sel,
  // Phy receive events.
  input wire logic i_rst_in_progress,
  input wire logic i_dword_sync,
  input wire logic i_invalid_dword,
  input wire logic i_disp_err,
  input wire logic i_sync_lost,
  input wire logic i_reset_problem,
  // Status outputs.
  output logic [7:0] o_gen_code,
  output logic o_irq
);

  spel_cnt_if cif ();

  logic phy_en;
  logic [31:0] mode;
  logic [spel_pkg::INT_W-1:0] int_stat;
  logic [spel_pkg::INT_W-1:0] int_mask;
  logic [spel_pkg::INT_W-1:0] int_events;
  logic [3:0] rate_code;
  logic [3:0] rate_shown;
  logic [2:0] att_dev_type;
  logic [2:0] att_init_bits;
  logic [2:0] att_tgt_bits;
  logic [63:0] att_sas_addr;
  logic [7:0] att_phy_id;
  logic [3:0] att_reason;
  logic [63:0] own_sas_addr;
  logic [3:0] own_reason;
  logic mode_change;
  logic [767:0] log_img;
  logic [31:0] next_rdata;

  // Next generation code, skipping the unknown value on wrap.
  function automatic logic [7:0] gen_step(input logic [7:0] g);
    if (g == spel_pkg::GEN_MAX)
      return spel_pkg::GEN_WRAP;
    else
      return g + 8'h01;
  endfunction

  // One word of the log image, counted from its first byte.
  function automatic logic [31:0] log_word(input logic [767:0] img, input logic [4:0] k);
    logic [767:0] sh;
    sh = img << (32 * k);
    return sh[767:736];
  endfunction

  // Event counter bank.
  spel_counters u_counters
  (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .cif(cif)
  );

  // Gate raw phy events into counter increments.
  assign cif.inc[spel_pkg::EV_INVALID] = i_invalid_dword && !i_rst_in_progress;
  assign cif.inc[spel_pkg::EV_DISP] = i_disp_err && i_dword_sync;
  assign cif.inc[spel_pkg::EV_SYNC] = i_sync_lost;
  assign cif.inc[spel_pkg::EV_RSTPRB] = i_reset_problem;

  // A write to the mode register that alters it counts as a settings change.
  assign mode_change = i_wr && i_addr == spel_pkg::ADDR_MODE && i_wdata != mode;

  // Control and mode registers.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      phy_en <= 1'b0;
      mode <= spel_pkg::MODE_RESET;
    end
    else if (i_wr && i_addr == spel_pkg::ADDR_CTRL)
      phy_en <= i_wdata[spel_pkg::CTRL_PHY_EN_BIT];
    else if (i_wr && i_addr == spel_pkg::ADDR_MODE)
      mode <= i_wdata;
  end

  // Generation code steps on each settings change.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_gen_code <= spel_pkg::GEN_UNKNOWN;
    else if (mode_change)
      o_gen_code <= gen_step(o_gen_code);
  end

  // Negotiated rate is latched at each completed link reset.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      rate_code <= spel_pkg::RATE_UNKNOWN;
    else if (i_link_up)
      rate_code <= spel_pkg::RATE_CODE_BASE + {2'b00, i_rate_sel};
  end

  // The rate is only meaningful while the phy is enabled.
  assign rate_shown = phy_en ? rate_code : spel_pkg::RATE_UNKNOWN;

  // Fields of the received frame.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      att_dev_type <= 3'h0;
      att_init_bits <= 3'h0;
      att_tgt_bits <= 3'h0;
      att_sas_addr <= 64'h0;
      att_phy_id <= 8'h00;
    end
    else if (i_rx_idf_valid)
    begin
      att_dev_type <= i_rx_dev_type;
      att_init_bits <= i_rx_init_bits;
      att_tgt_bits <= i_rx_tgt_bits;
      att_sas_addr <= i_rx_sas_addr;
      att_phy_id <= i_rx_phy_id;
    end
  end

  // Attached reason: a virtual phy and a SATA D2H FIS both force zero.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      att_reason <= spel_pkg::REASON_NONE;
    else if (i_virtual_phy)
      att_reason <= spel_pkg::REASON_NONE;
    else if (i_sata_attached && i_sata_d2h_fis)
      att_reason <= spel_pkg::REASON_NONE;
    else if (i_rx_idf_valid && !i_sata_attached)
      att_reason <= i_rx_reason;
  end

  // Own address and reason follow the last transmitted frame.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      own_sas_addr <= 64'h0;
      own_reason <= spel_pkg::REASON_NONE;
    end
    else if (i_tx_idf_valid)
    begin
      own_sas_addr <= i_tx_sas_addr;
      own_reason <= i_tx_reason;
    end
  end

  // Interrupt sources, one cycle wide each.
  assign int_events[spel_pkg::INT_RX_IDF] = i_rx_idf_valid;
  assign int_events[spel_pkg::INT_LINK_UP] = i_link_up;
  assign int_events[spel_pkg::INT_SYNC_LOST] = i_sync_lost;
  assign int_events[spel_pkg::INT_RST_PROBLEM] = i_reset_problem;

  // Sticky status, cleared by writing ones; a new event wins over the clear.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      int_stat <= '0;
    else if (i_wr && i_addr == spel_pkg::ADDR_INT_STAT)
      int_stat <= (int_stat & ~i_wdata[spel_pkg::INT_W-1:0]) | int_events;
    else
      int_stat <= int_stat | int_events;
  end

  // Interrupt mask.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      int_mask <= spel_pkg::MASK_RESET;
    else if (i_wr && i_addr == spel_pkg::ADDR_INT_MASK)
      int_mask <= i_wdata[spel_pkg::INT_W-1:0];
  end

  // Interrupt line is registered from the masked status.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_irq <= 1'b0;
    else
      o_irq <= |(int_stat & int_mask);
  end

  // Log image from byte 12 onward; multi-byte values are big-endian.
  assign log_img =
  {
    1'b0, att_dev_type, att_reason,
    own_reason, rate_shown,
    4'h0, att_init_bits, 1'b0,
    4'h0, att_tgt_bits, 1'b0,
    own_sas_addr,
    att_sas_addr, att_phy_id, 56'h0,
    cif.cnt[spel_pkg::EV_INVALID],
    cif.cnt[spel_pkg::EV_DISP],
    cif.cnt[spel_pkg::EV_SYNC],
    cif.cnt[spel_pkg::EV_RSTPRB],
    16'h0, spel_pkg::DESC_LEN, spel_pkg::DESC_COUNT,
    24'h0, spel_pkg::SRC_INVALID, cif.cnt[spel_pkg::EV_INVALID], spel_pkg::PEAK_THRESH,
    24'h0, spel_pkg::SRC_DISP, cif.cnt[spel_pkg::EV_DISP], spel_pkg::PEAK_THRESH,
    24'h0, spel_pkg::SRC_SYNC, cif.cnt[spel_pkg::EV_SYNC], spel_pkg::PEAK_THRESH,
    24'h0, spel_pkg::SRC_RSTPRB, cif.cnt[spel_pkg::EV_RSTPRB], spel_pkg::PEAK_THRESH
  };

  // Read decode; unmapped addresses answer zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (i_addr == spel_pkg::ADDR_CTRL)
      next_rdata = {31'h0, phy_en};
    else if (i_addr == spel_pkg::ADDR_MODE)
      next_rdata = mode;
    else if (i_addr == spel_pkg::ADDR_INT_STAT)
      next_rdata = {28'h0, int_stat};
    else if (i_addr == spel_pkg::ADDR_INT_MASK)
      next_rdata = {28'h0, int_mask};
    else if (i_addr == spel_pkg::ADDR_GEN)
      next_rdata = {24'h0, o_gen_code};
    else if (i_addr >= spel_pkg::ADDR_LOG_BASE && i_addr <= spel_pkg::ADDR_LOG_LAST && i_addr[1:0] == 2'b00)
      next_rdata = log_word(log_img, 5'(i_addr[6:2]));
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 32'h0000_0000;
  end

  // Checks on the core.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  property p_rate_code;
    (i_link_up && phy_en && !(i_wr && i_addr == spel_pkg::ADDR_CTRL))
      |=> rate_shown == spel_pkg::RATE_CODE_BASE + {2'b00, $past(i_rate_sel)};
  endproperty
  a_rate_code: assert property (p_rate_code) else $error("Rate code does not match negotiation.");

  property p_gen_wrap;
    (mode_change && o_gen_code == spel_pkg::GEN_MAX) |=> o_gen_code == spel_pkg::GEN_WRAP;
  endproperty
  a_gen_wrap: assert property (p_gen_wrap) else $error("Generation code did not wrap to one.");

  property p_gen_step;
    (mode_change && o_gen_code != spel_pkg::GEN_MAX) |=> o_gen_code == $past(o_gen_code) + 8'h01;
  endproperty
  a_gen_step: assert property (p_gen_step) else $error("Generation code did not step.");

  property p_invalid_gate;
    (i_invalid_dword && i_rst_in_progress)
      |=> cif.cnt[spel_pkg::EV_INVALID] == $past(cif.cnt[spel_pkg::EV_INVALID]);
  endproperty
  a_invalid_gate: assert property (p_invalid_gate) else $error("Invalid dword counted during reset.");

  property p_rx_capture;
    i_rx_idf_valid |=> att_sas_addr == $past(i_rx_sas_addr) && att_phy_id == $past(i_rx_phy_id);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("Far-end address not captured.");

  property p_att_reason_sata;
    (i_sata_attached && i_sata_d2h_fis) |=> att_reason == spel_pkg::REASON_NONE;
  endproperty
  a_att_reason_sata: assert property (p_att_reason_sata) else $error("Attached reason not cleared.");

  property p_tx_capture;
    i_tx_idf_valid |=> own_sas_addr == $past(i_tx_sas_addr) && own_reason == $past(i_tx_reason);
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("Own frame fields not captured.");

  property p_desc_header;
    (i_rd && i_addr == spel_pkg::ADDR_LOG_BASE + 8'h2C)
      |=> o_rdata == {16'h0, spel_pkg::DESC_LEN, spel_pkg::DESC_COUNT};
  endproperty
  a_desc_header: assert property (p_desc_header) else $error("Descriptor header wrong.");

  property p_peak_zero;
    (i_rd && i_addr == spel_pkg::ADDR_LOG_BASE + 8'h44) |=> o_rdata == spel_pkg::PEAK_THRESH;
  endproperty
  a_peak_zero: assert property (p_peak_zero) else $error("Peak threshold not zero.");

  property p_src_tag;
    (i_rd && i_addr == spel_pkg::ADDR_LOG_BASE + 8'h54) |=> o_rdata == {24'h0, spel_pkg::SRC_RSTPRB};
  endproperty
  a_src_tag: assert property (p_src_tag) else $error("Fourth source tag wrong.");

  property p_irq_follow;
    ##1 o_irq == |($past(int_stat) & $past(int_mask));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("Interrupt line wrong.");

  property p_disp_gate;
    (i_disp_err && !i_dword_sync) |=> cif.cnt[spel_pkg::EV_DISP] == $past(cif.cnt[spel_pkg::EV_DISP]);
  endproperty
  a_disp_gate: assert property (p_disp_gate) else $error("Disparity error counted without sync.");

  property p_sync_step;
    (i_sync_lost && cif.cnt[spel_pkg::EV_SYNC] != spel_pkg::CNT_MAX)
      |=> cif.cnt[spel_pkg::EV_SYNC] == $past(cif.cnt[spel_pkg::EV_SYNC]) + 32'h0000_0001;
  endproperty
  a_sync_step: assert property (p_sync_step) else $error("Sync loss count did not step.");

  property p_rstprb_step;
    (i_reset_problem && cif.cnt[spel_pkg::EV_RSTPRB] != spel_pkg::CNT_MAX)
      |=> cif.cnt[spel_pkg::EV_RSTPRB] == $past(cif.cnt[spel_pkg::EV_RSTPRB]) + 32'h0000_0001;
  endproperty
  a_rstprb_step: assert property (p_rstprb_step) else $error("Reset problem count did not step.");

  property p_rdata_idle;
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data stood without a read.");

  c_gen_wrap: cover property (mode_change && o_gen_code == spel_pkg::GEN_MAX);
  c_rx_then_read: cover property (i_rx_idf_valid ##[1:20] i_rd && i_addr == spel_pkg::ADDR_LOG_BASE);
  c_irq: cover property (o_irq);

endmodule

// >>> testbench/spel_far_phy.sv
// Model of the attached far-end phy that feeds frames, link results and receive events.
`timescale 1ns/1ps
module spel_far_phy
(
  // Clock.
  input wire logic i_clock,
  // Received frame fields.
  output logic o_idf_valid,
  output logic [2:0] o_dev_type,
  output logic [2:0] o_init_bits,
  output logic [2:0] o_tgt_bits,
  output logic [63:0] o_sas_addr,
  output logic [7:0] o_phy_id,
  output logic [3:0] o_reason,
  // Attachment and link outcome.
  output logic o_sata,
  output logic o_d2h_fis,
  output logic o_link_up,
  output logic [1:0] o_rate_sel,
  // Receive levels and event pulses.
  output logic o_rst_busy,
  output logic o_dword_sync,
  output logic [3:0] o_ev
);
  // Idle state at time zero.
  initial
  begin
    o_idf_valid = 1'b0;
    o_dev_type = 3'h0;
    o_init_bits = 3'h0;
    o_tgt_bits = 3'h0;
    o_sas_addr = 64'h0;
    o_phy_id = 8'h0;
    o_reason = 4'h0;
    o_sata = 1'b0;
    o_d2h_fis = 1'b0;
    o_link_up = 1'b0;
    o_rate_sel = 2'h0;
    o_rst_busy = 1'b0;
    o_dword_sync = 1'b1;
    o_ev = 4'h0;
  end

  // Sends one frame; fields are scrambled afterwards so stale values cannot pass.
  task automatic send_idf(input logic [2:0] dt, input logic [2:0] ib, input logic [2:0] tb,
                          input logic [63:0] a, input logic [7:0] id, input logic [3:0] rs);
    @(posedge i_clock);
    o_idf_valid <= 1'b1;
    o_dev_type <= dt;
    o_init_bits <= ib;
    o_tgt_bits <= tb;
    o_sas_addr <= a;
    o_phy_id <= id;
    o_reason <= rs;
    @(posedge i_clock);
    o_idf_valid <= 1'b0;
    o_dev_type <= ~dt;
    o_init_bits <= ~ib;
    o_tgt_bits <= ~tb;
    o_sas_addr <= ~a;
    o_phy_id <= ~id;
    o_reason <= ~rs;
  endtask

  // Finishes a link reset at the given rate; the rate lines invert afterwards.
  task automatic link(input logic [1:0] r);
    @(posedge i_clock);
    o_link_up <= 1'b1;
    o_rate_sel <= r;
    @(posedge i_clock);
    o_link_up <= 1'b0;
    o_rate_sel <= ~r;
  endtask

  // Sends the first register device-to-host frame of a SATA device.
  task automatic fis;
    @(posedge i_clock);
    o_d2h_fis <= 1'b1;
    @(posedge i_clock);
    o_d2h_fis <= 1'b0;
  endtask

  // Holds one event line high for n cycles.
  task automatic pulse(input int i, input int n);
    @(posedge i_clock);
    o_ev[i] <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_ev[i] <= 1'b0;
  endtask

  // Sets the attachment kind and the receive condition levels.
  task automatic set_lv(input logic sata, input logic busy, input logic sync);
    @(posedge i_clock);
    o_sata <= sata;
    o_rst_busy <= busy;
    o_dword_sync <= sync;
  endtask
endmodule

// >>> testbench/spel_top_tb.sv
// Self-checking bench for the phy event log block.
`timescale 1ns/1ps
module spel_top_tb;
  typedef struct { logic [7:0] addr; logic [31:0] exp; } spel_row_t;
  logic i_clock, i_srst, i_wr, i_rd, i_tx_idf_valid, i_virtual_phy;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [63:0] i_tx_sas_addr;
  logic [3:0] i_tx_reason;
  logic rv, sata, fisv, lup, busy, sync, o_irq;
  logic [2:0] dt, ib, tb;
  logic [63:0] ra;
  logic [7:0] pid, o_gen_code;
  logic [3:0] rs, ev;
  logic [1:0] rsel;
  int fail_count = 0;
  int n_checks = 0;
  // Register values after reset and the fixed descriptor words.
  spel_row_t rows [15] = '{'{8'h10, 32'h0}, '{8'h08, 32'h0}, '{8'h0C, 32'h0}, '{8'h00, 32'h0},
    '{8'h98, 32'h0}, '{8'h9C, 32'h0}, '{8'hA8, 32'h0}, '{8'hAC, 32'h0C04}, '{8'hB0, 32'h1},
    '{8'hBC, 32'h2}, '{8'hC8, 32'h3}, '{8'hD4, 32'h4}, '{8'hB8, 32'h0}, '{8'hDC, 32'h0}, '{8'h40, 32'h0}};
  logic [31:0] cnt_exp [4] = '{32'h3, 32'h2, 32'h1, 32'h1};

  spel_top u_dut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_idf_valid(rv), .i_rx_dev_type(dt), .i_rx_init_bits(ib),
    .i_rx_tgt_bits(tb), .i_rx_sas_addr(ra), .i_rx_phy_id(pid), .i_rx_reason(rs),
    .i_tx_idf_valid(i_tx_idf_valid), .i_tx_sas_addr(i_tx_sas_addr), .i_tx_reason(i_tx_reason),
    .i_sata_attached(sata), .i_sata_d2h_fis(fisv), .i_virtual_phy(i_virtual_phy), .i_link_up(lup),
    .i_rate_sel(rsel), .i_rst_in_progress(busy), .i_dword_sync(sync), .i_invalid_dword(ev[0]),
    .i_disp_err(ev[1]), .i_sync_lost(ev[2]), .i_reset_problem(ev[3]), .o_gen_code(o_gen_code),
    .o_irq(o_irq));

  spel_far_phy u_far (.i_clock(i_clock), .o_idf_valid(rv), .o_dev_type(dt), .o_init_bits(ib),
    .o_tgt_bits(tb), .o_sas_addr(ra), .o_phy_id(pid), .o_reason(rs), .o_sata(sata), .o_d2h_fis(fisv),
    .o_link_up(lup), .o_rate_sel(rsel), .o_rst_busy(busy), .o_dword_sync(sync), .o_ev(ev));

  // Clock at 10 MHz.
  initial
  begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp, what);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Stops a hung run well after the tests should have ended.
  initial
  begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_tx_idf_valid = 1'b0;
    i_tx_sas_addr = 64'h0;
    i_tx_reason = 4'h0;
    i_virtual_phy = 1'b0;
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    for (int k = 0; k < 15; k++)
      rd_chk(rows[k].addr, rows[k].exp, "reset row");
    $display("Test rows done");
    u_far.pulse(spel_pkg::EV_INVALID, 3);
    u_far.set_lv(1'b0, 1'b1, 1'b1);
    u_far.pulse(spel_pkg::EV_INVALID, 2);
    u_far.set_lv(1'b0, 1'b0, 1'b1);
    u_far.pulse(spel_pkg::EV_DISP, 2);
    u_far.set_lv(1'b0, 1'b0, 1'b0);
    u_far.pulse(spel_pkg::EV_DISP, 1);
    u_far.set_lv(1'b0, 1'b0, 1'b1);
    u_far.pulse(spel_pkg::EV_SYNC, 1);
    u_far.pulse(spel_pkg::EV_RSTPRB, 1);
    for (int k = 0; k < 4; k++)
    begin
      rd_chk(8'h9C + 8'(4 * k), cnt_exp[k], "count");
      rd_chk(8'hB4 + 8'(12 * k), cnt_exp[k], "event value");
    end
    $display("Test counters done");
    // Sync loss and reset problem set status; only the unmasked one raises the line.
    rd_chk(spel_pkg::ADDR_INT_STAT, 32'hC, "status");
    chk({31'h0, o_irq}, 32'h0, "irq masked");
    wr(spel_pkg::ADDR_INT_MASK, 32'h4);
    repeat (2) @(posedge i_clock);
    #1;
    chk({31'h0, o_irq}, 32'h1, "irq raised");
    wr(spel_pkg::ADDR_INT_STAT, 32'h4);
    repeat (2) @(posedge i_clock);
    #1;
    chk({31'h0, o_irq}, 32'h0, "irq cleared");
    rd_chk(spel_pkg::ADDR_INT_STAT, 32'h8, "status after clear");
    $display("Test interrupt done");
    // Frame capture and rate codes for every rate.
    wr(spel_pkg::ADDR_CTRL, 32'h1);
    u_far.send_idf(3'h1, 3'h5, 3'h2, 64'h0123_4567_89AB_CDEF, 8'h5A, 4'h6);
    @(posedge i_clock);
    i_tx_idf_valid <= 1'b1;
    i_tx_sas_addr <= 64'hFEDC_BA98_7654_3210;
    i_tx_reason <= 4'h3;
    @(posedge i_clock);
    i_tx_idf_valid <= 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      u_far.link(2'(r));
      rd_chk(8'h80, {1'b0, 3'h1, 4'h6, 4'h3, 4'h8 + 4'(r), 4'h0, 3'h5, 1'b0, 4'h0, 3'h2, 1'b0}, "id word");
    end
    wr(spel_pkg::ADDR_CTRL, 32'h0);
    rd_chk(8'h80, {1'b0, 3'h1, 4'h6, 4'h3, 4'h0, 4'h0, 3'h5, 1'b0, 4'h0, 3'h2, 1'b0}, "rate disabled");
    rd_chk(8'h84, 32'hFEDC_BA98, "own addr hi");
    rd_chk(8'h88, 32'h7654_3210, "own addr lo");
    rd_chk(8'h8C, 32'h0123_4567, "far addr hi");
    rd_chk(8'h90, 32'h89AB_CDEF, "far addr lo");
    rd_chk(8'h94, 32'h5A00_0000, "far phy id");
    $display("Test frames done");
    // Attached reason under SATA, after the first device frame, and on a virtual phy.
    u_far.set_lv(1'b1, 1'b0, 1'b1);
    u_far.send_idf(3'h1, 3'h5, 3'h2, 64'h1, 8'h1, 4'h9);
    rd(8'h80, d);
    chk({28'h0, d[27:24]}, 32'h6, "sata reason held");
    u_far.fis();
    rd(8'h80, d);
    chk({28'h0, d[27:24]}, 32'h0, "sata reason cleared");
    u_far.set_lv(1'b0, 1'b0, 1'b1);
    u_far.send_idf(3'h2, 3'h1, 3'h4, 64'h2, 8'h2, 4'h7);
    rd(8'h80, d);
    chk({28'h0, d[27:24]}, 32'h7, "sas reason");
    @(posedge i_clock);
    i_virtual_phy <= 1'b1;
    rd(8'h80, d);
    chk({28'h0, d[27:24]}, 32'h0, "virtual reason");
    $display("Test reason done");
    // Generation code through the wrap, then a repeated value.
    for (int k = 1; k <= 256; k++)
    begin
      wr(spel_pkg::ADDR_MODE, 32'(k));
      @(posedge i_clock);
      #1;
      chk({24'h0, o_gen_code}, (k == 256) ? 32'h1 : 32'(k), "gen code");
    end
    wr(spel_pkg::ADDR_MODE, 32'd256);
    rd_chk(spel_pkg::ADDR_GEN, 32'h1, "gen unchanged");
    // Writes to the read-only log and to an unmapped place are ignored.
    wr(8'hB0, 32'hFFFF_FFFF);
    rd_chk(8'hB0, 32'h1, "log write ignored");
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0, "unmapped");
    $display("Test gen and access done");
    wrap_up();
  end
endmodule
